// *** src/doic_pkg.sv ***
// constants for the dual output interrupt controller
package doic_pkg;
  localparam int SRC_W = 21;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int EXT_W = 8;
  localparam int EXT_LO = 0;
  localparam int RSV_LO = 8;
  localparam int RSV_W = 2;
  localparam int PER_LO = 10;
  localparam int PER_W = 10;
  localparam int SWI_BIT = 20;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_MASK = 16'h1200;
  localparam logic [ADDR_W-1:0] OFS_TRIG_MODE = 16'h1204;
  localparam logic [ADDR_W-1:0] OFS_TRIG_POL = 16'h1208;
  localparam logic [ADDR_W-1:0] OFS_ROUTE = 16'h120c;
  localparam logic [ADDR_W-1:0] OFS_FAST_STATUS = 16'h1210;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_STATUS = 16'h1214;
  localparam logic [ADDR_W-1:0] OFS_FAST_MASK = 16'h1218;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_MASK = 16'h121c;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CLEAR = 16'h1220;
  localparam logic [SRC_W-1:0] GLOBAL_MASK_RST = 21'h1fffff;
  localparam logic [SRC_W-1:0] TRIG_MODE_RST = 21'h000000;
  localparam logic [SRC_W-1:0] TRIG_POL_RST = 21'h000000;
  localparam logic [SRC_W-1:0] ROUTE_RST = 21'h000000;
  localparam logic [SRC_W-1:0] OUT_MASK_RST = 21'h000000;
  localparam logic [SRC_W-1:0] ZERO_SRC = 21'h000000;
  localparam logic [DATA_W-1:0] ZERO_DATA = 32'h00000000;
  localparam logic [RSV_W-1:0] ZERO_RSV = 2'h0;
endpackage : doic_pkg

// *** src/doic_detect.sv ***
// one source: optional synchroniser, edge or level detection, status flag
`timescale 1ns/1ps
module doic_detect #(
  parameter bit SYNC = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source and its configuration
  input wire logic raw,
  input wire logic level_mode,
  input wire logic active_high,
  input wire logic clear,
  input wire logic block,
  // detected state
  output logic status
);
  logic s;
  logic prev;
  logic edge_hit;
  logic level_act;
  logic next_status;

  generate
    if (SYNC) begin : g_sync
      logic meta;
      logic stable;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= raw;
          stable <= meta;
        end
      end
      assign s = stable;
    end else begin : g_direct
      assign s = raw;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
      status <= 1'b0;
    end else begin
      prev <= s;
      status <= next_status;
    end
  end

  assign edge_hit = active_high ? (s & ~prev) : (~s & prev);
  assign level_act = active_high ? s : ~s;
  // a new edge beats a clear in the same cycle; level mode ignores clears
  assign next_status = block ? 1'b0 :
                       level_mode ? level_act :
                       edge_hit ? 1'b1 :
                       clear ? 1'b0 : status;
endmodule : doic_detect

// *** src/doic_top.sv ***
// dual output interrupt controller with apb register slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
// What this block does
// - 21 sources: 0-7 external, 8-9 reserved, 10-19 peripherals, 20 software
// - sources 0-19 have a selectable detection mode; reset gives falling edge
// - no priority logic and no vectors; software orders via output masks
// - global mask bits 0-19: 1 blocks a source, 0 lets it through
// - setting a global mask bit 0-19 clears that source's status
// - reset sets every global mask bit: sources 0-19 masked, software source 20 raised
// - trigger mode 0 means edge, 1 means level; reset is edge
// - polarity 0 falling or low, 1 rising or high; reset falling
// - route bit 0 to normal output, 1 to fast; reset normal
// - separate fast and normal status registers show routed detected sources
// - writing 1 to status clear clears status of edge sources only
// - per-output masks decide whether a routed active source drives output
// - source 20 is software, active high level, follows mask register bit 20
// - output masks let software steer and suppress requests
// - nine registers at fixed offsets, global mask lowest, clear highest
// - status clear bits written 0 leave status unchanged
// - output mask bit 1 disables, 0 enables; reset all enabled
module doic_top
  import doic_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources
  input wire logic [EXT_W-1:0] ext_irq_in,
  input wire logic [PER_W-1:0] periph_irq_in,
  // requests toward the processor, active high
  output logic fast_irq,
  output logic normal_irq
);
  logic [SRC_W-1:0] global_source_mask;
  logic [SRC_W-1:0] trigger_mode_select;
  logic [SRC_W-1:0] trigger_polarity_select;
  logic [SRC_W-1:0] output_route_select;
  logic [SRC_W-1:0] fast_output_mask;
  logic [SRC_W-1:0] normal_output_mask;
  logic [SRC_W-1:0] status_vec;
  logic [SRC_W-1:0] raw_vec;
  logic [SRC_W-1:0] mode_vec;
  logic [SRC_W-1:0] pol_vec;
  logic [SRC_W-1:0] block_vec;
  logic [SRC_W-1:0] clear_vec;
  logic [SRC_W-1:0] fast_output_status;
  logic [SRC_W-1:0] normal_output_status;
  logic [SRC_W-1:0] wdata;
  logic [DATA_W-1:0] next_prdata;
  logic setup;
  logic wr_access;
  logic addr_hit;
  logic next_fast_irq;
  logic next_normal_irq;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait-free access phase after every setup
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pready & pwrite;
  assign wdata = pwdata[SRC_W-1:0];

  assign addr_hit = (paddr == OFS_GLOBAL_MASK) | (paddr == OFS_TRIG_MODE) |
                    (paddr == OFS_TRIG_POL) | (paddr == OFS_ROUTE) |
                    (paddr == OFS_FAST_STATUS) | (paddr == OFS_NORMAL_STATUS) |
                    (paddr == OFS_FAST_MASK) | (paddr == OFS_NORMAL_MASK) |
                    (paddr == OFS_STATUS_CLEAR);

  // status clear reads as zero; upper bits always zero
  assign next_prdata =
    (paddr == OFS_GLOBAL_MASK) ? {11'h000, global_source_mask} :
    (paddr == OFS_TRIG_MODE) ? {11'h000, trigger_mode_select} :
    (paddr == OFS_TRIG_POL) ? {11'h000, trigger_polarity_select} :
    (paddr == OFS_ROUTE) ? {11'h000, output_route_select} :
    (paddr == OFS_FAST_STATUS) ? {11'h000, fast_output_status} :
    (paddr == OFS_NORMAL_STATUS) ? {11'h000, normal_output_status} :
    (paddr == OFS_FAST_MASK) ? {11'h000, fast_output_mask} :
    (paddr == OFS_NORMAL_MASK) ? {11'h000, normal_output_mask} :
    ZERO_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= ZERO_DATA;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_hit;
      prdata <= (setup & ~pwrite) ? next_prdata : ZERO_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; status registers are read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_source_mask <= GLOBAL_MASK_RST;
      trigger_mode_select <= TRIG_MODE_RST;
      trigger_polarity_select <= TRIG_POL_RST;
      output_route_select <= ROUTE_RST;
      fast_output_mask <= OUT_MASK_RST;
      normal_output_mask <= OUT_MASK_RST;
    end else if (wr_access) begin
      if (paddr == OFS_GLOBAL_MASK) global_source_mask <= wdata;
      if (paddr == OFS_TRIG_MODE) trigger_mode_select <= wdata;
      if (paddr == OFS_TRIG_POL) trigger_polarity_select <= wdata;
      if (paddr == OFS_ROUTE) output_route_select <= wdata;
      if (paddr == OFS_FAST_MASK) fast_output_mask <= wdata;
      if (paddr == OFS_NORMAL_MASK) normal_output_mask <= wdata;
    end
  end

  // write-one-to-clear pulse, zeros leave status alone
  assign clear_vec = (wr_access && paddr == OFS_STATUS_CLEAR) ? wdata : ZERO_SRC;

  ////////////////////////////////////////////////////////////////////////////
  // source map; reserved positions have nothing behind them
  assign raw_vec = {global_source_mask[SWI_BIT], periph_irq_in, ZERO_RSV,
                    ext_irq_in};
  // software source is fixed high level and not blocked by its own bit
  assign mode_vec = {1'b1, trigger_mode_select[SWI_BIT-1:0]};
  assign pol_vec = {1'b1, trigger_polarity_select[SWI_BIT-1:0]};
  assign block_vec = {1'b0, global_source_mask[SWI_BIT-1:0]};

  genvar gi;
  generate
    for (gi = 0; gi < SRC_W; gi++) begin : g_src
      // pins and foreign peripherals are synchronised; the software bit is ours
      doic_detect #(
        .SYNC(gi != SWI_BIT)
      ) u_det (
        .pclk(pclk),
        .presetn(presetn),
        .raw(raw_vec[gi]),
        .level_mode(mode_vec[gi]),
        .active_high(pol_vec[gi]),
        .clear(clear_vec[gi]),
        .block(block_vec[gi]),
        .status(status_vec[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // routing and output gating; plain or-reduce, no priority, no vector
  assign fast_output_status = status_vec & output_route_select;
  assign normal_output_status = status_vec & ~output_route_select;
  assign next_fast_irq = |(fast_output_status & ~fast_output_mask);
  assign next_normal_irq = |(normal_output_status & ~normal_output_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_irq <= 1'b0;
      normal_irq <= 1'b0;
    end else begin
      fast_irq <= next_fast_irq;
      normal_irq <= next_normal_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_gmask_reset;
    @(posedge pclk) $rose(presetn) |-> global_source_mask == GLOBAL_MASK_RST;
  endproperty
  a_gmask_reset: assert property (p_gmask_reset) else $error("mask not all set after reset");

  property p_masked_cleared;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (status_vec & $past(block_vec)) == ZERO_SRC;
  endproperty
  a_masked_cleared: assert property (p_masked_cleared) else $error("masked source kept status");

  property p_fast_out;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> fast_irq == $past(|(status_vec & output_route_select & ~fast_output_mask));
  endproperty
  a_fast_out: assert property (p_fast_out) else $error("fast output mismatch");

  property p_normal_out;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> normal_irq == $past(|(status_vec & ~output_route_select & ~normal_output_mask));
  endproperty
  a_normal_out: assert property (p_normal_out) else $error("normal output mismatch");

  property p_route_split;
    @(posedge pclk) disable iff (!presetn)
      ((fast_output_status & normal_output_status) == ZERO_SRC) &&
      ((fast_output_status | normal_output_status) == status_vec);
  endproperty
  a_route_split: assert property (p_route_split) else $error("status routed to both");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (($past(status_vec) & ~$past(clear_vec) & ~$past(mode_vec) &
                 ~$past(block_vec)) & ~status_vec) == ZERO_SRC;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("edge status lost without clear");

  property p_swi;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> status_vec[SWI_BIT] == $past(global_source_mask[SWI_BIT]);
  endproperty
  a_swi: assert property (p_swi) else $error("software request not raised");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
      status_vec[RSV_LO +: RSV_W] == ZERO_RSV;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved source active");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready || setup;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");

  property p_mode_write;
    @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == OFS_TRIG_MODE |=> trigger_mode_select == $past(wdata);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("trigger mode write lost");

  property p_gm_write;
    @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == OFS_GLOBAL_MASK |=> global_source_mask == $past(wdata);
  endproperty
  a_gm_write: assert property (p_gm_write) else $error("global mask write lost");

  property p_pol_write;
    @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == OFS_TRIG_POL |=> trigger_polarity_select == $past(wdata);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity write lost");

  property p_route_write;
    @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == OFS_ROUTE |=> output_route_select == $past(wdata);
  endproperty
  a_route_write: assert property (p_route_write) else $error("route write lost");

  property p_fmask_write;
    @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == OFS_FAST_MASK |=> fast_output_mask == $past(wdata);
  endproperty
  a_fmask_write: assert property (p_fmask_write) else $error("fast mask write lost");

  property p_nmask_write;
    @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == OFS_NORMAL_MASK |=> normal_output_mask == $past(wdata);
  endproperty
  a_nmask_write: assert property (p_nmask_write) else $error("normal mask write lost");

  property p_cfg_reset;
    @(posedge pclk)
      $rose(presetn) |-> trigger_mode_select == TRIG_MODE_RST &&
      trigger_polarity_select == TRIG_POL_RST;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("detection not falling edge after reset");

  property p_route_reset;
    @(posedge pclk)
      $rose(presetn) |-> output_route_select == ROUTE_RST;
  endproperty
  a_route_reset: assert property (p_route_reset) else $error("route not normal after reset");

  property p_omask_reset;
    @(posedge pclk)
      $rose(presetn) |-> fast_output_mask == OUT_MASK_RST && normal_output_mask == OUT_MASK_RST;
  endproperty
  a_omask_reset: assert property (p_omask_reset) else $error("output masks not clear after reset");

  property p_quiet;
    @(posedge pclk) disable iff (!presetn)
      !(|status_vec) |=> !fast_irq && !normal_irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("request with no detected source");

  property p_fmask_all;
    @(posedge pclk) disable iff (!presetn)
      (&fast_output_mask) |=> !fast_irq;
  endproperty
  a_fmask_all: assert property (p_fmask_all) else $error("fast request through full mask");

  property p_nmask_all;
    @(posedge pclk) disable iff (!presetn)
      (&normal_output_mask) |=> !normal_irq;
  endproperty
  a_nmask_all: assert property (p_nmask_all) else $error("normal request through full mask");

  property p_route_none;
    @(posedge pclk) disable iff (!presetn)
      output_route_select == ZERO_SRC |=> !fast_irq;
  endproperty
  a_route_none: assert property (p_route_none) else $error("fast request with nothing routed");

  property p_route_all;
    @(posedge pclk) disable iff (!presetn)
      (&output_route_select) |=> !normal_irq;
  endproperty
  a_route_all: assert property (p_route_all) else $error("normal request with all routed fast");

  property p_gm_blocks;
    @(posedge pclk) disable iff (!presetn)
      presetn && (&global_source_mask[SWI_BIT-1:0]) |=> !(|status_vec[SWI_BIT-1:0]);
  endproperty
  a_gm_blocks: assert property (p_gm_blocks) else $error("masked hardware source detected");

  property p_all_blocked;
    @(posedge pclk) disable iff (!presetn)
      presetn && (&global_source_mask[SWI_BIT-1:0]) && !global_source_mask[SWI_BIT] |->
      ##2 !fast_irq && !normal_irq;
  endproperty
  a_all_blocked: assert property (p_all_blocked) else $error("request while all masked");

  property p_read_idle;
    @(posedge pclk) disable iff (!presetn)
      !(setup && !pwrite) |=> prdata == ZERO_DATA;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside a read");

  property p_slverr_pair;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_slverr_pair: assert property (p_slverr_pair) else $error("error without ready");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      wr_access && !addr_hit |=> $stable(global_source_mask) && $stable(normal_output_mask);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write took effect");

  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      ~|prdata[DATA_W-1:SRC_W];
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data above source bits");
endmodule : doic_top

// *** verification/doic_core_model.sv ***
// processor core model: counts rising fast and normal requests
`timescale 1ns/1ps
module doic_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the controller
  input wire logic fast_irq,
  input wire logic normal_irq,
  // rising requests seen
  output int fast_seen,
  output int normal_seen
);
  logic fast_q;
  logic normal_q;
  // only two levels arrive, no vector is fetched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_q <= 1'b0;
      normal_q <= 1'b0;
      fast_seen <= 0;
      normal_seen <= 0;
    end else begin
      fast_q <= fast_irq;
      normal_q <= normal_irq;
      if (fast_irq && !fast_q) fast_seen <= fast_seen + 1;
      if (normal_irq && !normal_q) normal_seen <= normal_seen + 1;
    end
  end
endmodule : doic_core_model

// *** verification/doic_top_tb.sv ***
// self-checking bench for the dual output interrupt controller
`timescale 1ns/1ps
module doic_top_tb;
  import doic_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 16'h0000;
  logic [DATA_W-1:0] pwdata = 32'h00000000;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [EXT_W-1:0] ext_irq_in = 8'h00;
  logic [PER_W-1:0] periph_irq_in = 10'h000;
  logic fast_irq;
  logic normal_irq;
  int fast_seen;
  int normal_seen;
  int err_count = 0;
  int checks_done = 0;
  logic [DATA_W-1:0] q;
  logic e;
  always #12.5 pclk = ~pclk;
  doic_top u_doic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_in(ext_irq_in), .periph_irq_in(periph_irq_in),
    .fast_irq(fast_irq), .normal_irq(normal_irq));
  doic_core_model u_doic_core_model (.pclk(pclk), .presetn(presetn), .fast_irq(fast_irq),
    .normal_irq(normal_irq), .fast_seen(fast_seen), .normal_seen(normal_seen));
  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      $display("mismatch pready expected 1 seen 0");
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, ZERO_DATA);
    chk($sformatf("reg %h", a), exp, q);
  endtask : rd
  task wt(input logic fsel, input logic val);
    int n;
    logic seen;
    seen = ~val;
    for (n = 0; n < 12 && seen !== val; n++) begin
      @(posedge pclk);
      #1 seen = fsel ? fast_irq : normal_irq;
    end
    checks_done++;
    if (seen !== val) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", fsel ? "fast_irq" : "normal_irq", val, seen);
      conclude();
    end
  endtask : wt
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    apb(1'b1, OFS_NORMAL_MASK, 32'h00100000);
    rd(OFS_GLOBAL_MASK, 32'h001fffff);
    rd(OFS_TRIG_MODE, 32'h00000000);
    rd(OFS_TRIG_POL, 32'h00000000);
    rd(OFS_ROUTE, 32'h00000000);
    rd(OFS_FAST_STATUS, 32'h00000000);
    rd(OFS_NORMAL_STATUS, 32'h00100000);
    rd(OFS_FAST_MASK, 32'h00000000);
    rd(OFS_NORMAL_MASK, 32'h00100000);
    chk("pslverr", 32'h0, e);
    rd(OFS_STATUS_CLEAR, 32'h00000000);
    rd(16'h1224, 32'h00000000);
    chk("pslverr", 32'h1, e);
  endtask : t_reset
  task t_edge;
    apb(1'b1, OFS_GLOBAL_MASK, 32'h001ffffe);
    @(posedge pclk);
    ext_irq_in <= 8'h01;
    // hold long enough for the synchroniser
    repeat (3) @(posedge pclk);
    ext_irq_in <= 8'h00;
    wt(1'b0, 1'b1);
    chk("fast_irq", 32'h0, fast_irq);
    // software source stays active in the normal status, masked only at the output
    rd(OFS_NORMAL_STATUS, 32'h00100001);
    apb(1'b1, OFS_STATUS_CLEAR, 32'h001ffffe);
    rd(OFS_NORMAL_STATUS, 32'h00100001);
    apb(1'b1, OFS_STATUS_CLEAR, 32'h00000001);
    wt(1'b0, 1'b0);
    rd(OFS_NORMAL_STATUS, 32'h00100000);
    apb(1'b1, OFS_TRIG_POL, 32'h00000002);
    apb(1'b1, OFS_GLOBAL_MASK, 32'h001ffffd);
    ext_irq_in <= 8'h02;
    wt(1'b0, 1'b1);
    apb(1'b1, OFS_STATUS_CLEAR, 32'h00000002);
    ext_irq_in <= 8'h00;
    wt(1'b0, 1'b0);
  endtask : t_edge
  task t_level;
    apb(1'b1, OFS_TRIG_MODE, 32'h00000400);
    apb(1'b1, OFS_TRIG_POL, 32'h00000400);
    apb(1'b1, OFS_ROUTE, 32'h00000400);
    apb(1'b1, OFS_GLOBAL_MASK, 32'h001ffbff);
    periph_irq_in <= 10'h001;
    wt(1'b1, 1'b1);
    chk("normal_irq", 32'h0, normal_irq);
    apb(1'b1, OFS_STATUS_CLEAR, 32'h00000400);
    rd(OFS_FAST_STATUS, 32'h00000400);
    apb(1'b1, OFS_FAST_MASK, 32'h00000400);
    wt(1'b1, 1'b0);
    rd(OFS_FAST_STATUS, 32'h00000400);
    apb(1'b1, OFS_FAST_MASK, 32'h00000000);
    wt(1'b1, 1'b1);
    apb(1'b1, OFS_GLOBAL_MASK, 32'h001fffff);
    rd(OFS_FAST_STATUS, 32'h00000000);
    chk("fast_irq", 32'h0, fast_irq);
    periph_irq_in <= 10'h000;
    // low level on source 11, idle pin counts as active
    apb(1'b1, OFS_TRIG_MODE, 32'h00000800);
    apb(1'b1, OFS_GLOBAL_MASK, 32'h001ff7ff);
    wt(1'b0, 1'b1);
    @(posedge pclk);
    periph_irq_in <= 10'h002;
    wt(1'b0, 1'b0);
  endtask : t_level
  task t_soft;
    apb(1'b1, OFS_NORMAL_MASK, 32'h00000000);
    wt(1'b0, 1'b1);
    rd(OFS_NORMAL_STATUS, 32'h00100000);
    apb(1'b1, OFS_GLOBAL_MASK, 32'h000fffff);
    wt(1'b0, 1'b0);
    chk("fast count", 32'h2, fast_seen);
    chk("normal count", 32'h5, normal_seen);
  endtask : t_soft
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_edge();
    t_level();
    t_soft();
    conclude();
  end
endmodule : doic_top_tb
